// [src/timer16_with_edge_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module timer16_with_edge_capture
  import timer16_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = COUNT_W
)
(
  input wire logic I_SYS_CLK, // System clock, 10 MHz
  input wire logic I_ARST_N, // Async reset, active low
  input wire logic I_COUNTER_ON, // Counter run bit
  input wire logic I_COUNTER_GATE_ENABLE, // Gate qualifies counting
  input wire logic [1:0] I_COUNTER_CLOCK_SELECT, // Counter clock source
  input wire logic I_CRYSTAL_OSC_ENABLE, // Crystal selected for source 10
  input wire logic I_EXT_SYNC, // 1: resync external edges
  input wire logic [1:0] I_COUNTER_PRESCALE, // Divide by 1, 2, 4, 8
  input wire logic [1:0] I_GATE_SOURCE, // Gate pin or comparator
  input wire logic I_GATE_POLARITY, // Gate active level
  input wire logic I_COUNT_GATE_PIN, // Gate pin, async
  input wire logic I_COMPARATOR_ONE, // Comparator one output, async
  input wire logic I_COMPARATOR_TWO, // Comparator two output, async
  input wire logic I_EXT_COUNT_CLOCK_PIN, // External count clock pin, async
  input wire logic I_CRYSTAL_CLK, // Crystal oscillator output, async
  input wire logic [7:0] I_WR_DATA, // Count write data
  input wire logic I_COUNT_HIGH_WR, // Write high byte pulse
  input wire logic I_COUNT_LOW_WR, // Write low byte pulse
  input wire logic [3:0] I_CAPTURE_MODE_FIELD, // Capture mode
  input wire logic I_CAPTURE_PIN, // Capture pin input, async
  input wire logic I_PIN_DIRECTION, // 1: capture pin is input
  input wire logic I_PORT_LATCH, // Port bit written by software
  input wire logic I_CAPTURE_IRQ_FLAG_CLR, // Flag clear pulse
  output logic [7:0] O_COUNT_HIGH_BYTE, // Count high byte
  output logic [7:0] O_COUNT_LOW_BYTE, // Count low byte
  output logic [7:0] O_CAPTURE_HOLD_HIGH, // Held capture high byte
  output logic [7:0] O_CAPTURE_HOLD_LOW, // Held capture low byte
  output logic O_CAPTURE_IRQ_FLAG, // Capture flag, sticky
  output logic O_CAPTURE_PIN_OUT, // Capture pin drive level
  output logic O_CAPTURE_PIN_OE // Capture pin drive enable
);
  generate
    if (COUNT_WIDTH != 16)
    begin : g_bad_width
      $error("counter is built as two bytes; COUNT_WIDTH must be 16");
    end
  endgenerate

  // Registers
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [1:0] instr_q_r;
  logic [1:0] instr_q_nxt;
  logic [2:0] pre_r;
  logic [2:0] pre_nxt;
  logic arm_r;
  logic arm_nxt;
  logic resync_r;
  logic resync_nxt;
  logic flag_r;
  logic flag_nxt;
  logic pin_out_r;
  logic pin_oe_r;
  logic cap_meta_r;
  logic cap_sync_r;

  // Synchronised pin views
  logic [SYNC_BITS-1:0] raw_pins;
  logic [SYNC_BITS-1:0] pin_level;
  logic [SYNC_BITS-1:0] pin_rise;
  logic [SYNC_BITS-1:0] pin_fall;

  // Decode
  logic instr_tick;
  logic count_write;
  logic ext_src;
  logic xtal_src;
  logic pin_src;
  logic src_tick;
  logic [2:0] pre_last;
  logic pre_tick;
  logic gate_level;
  logic gate_ok;
  logic run;
  logic count_step;
  logic inc_now;
  logic cap_level;
  logic [15:0] hold;
  logic cap_fire;

  assign raw_pins = {I_CRYSTAL_CLK, I_EXT_COUNT_CLOCK_PIN, I_COMPARATOR_TWO, I_COMPARATOR_ONE, I_COUNT_GATE_PIN};

  pin_sync_edge #(
    .WIDTH(SYNC_BITS)
  ) u_pin_sync (
    .i_clk(I_SYS_CLK),
    .i_arst_n(I_ARST_N),
    .i_async(raw_pins),
    .o_level(pin_level),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // Instruction clock: one tick every four system clocks
  assign instr_q_nxt = instr_q_r + 2'h1;
  assign instr_tick = (instr_q_r == INSTR_LAST);

  assign count_write = I_COUNT_HIGH_WR | I_COUNT_LOW_WR;

  // Clock source selection
  assign ext_src = (I_COUNTER_CLOCK_SELECT == CS_EXT);
  assign xtal_src = ext_src & I_CRYSTAL_OSC_ENABLE;
  assign pin_src = ext_src & ~I_CRYSTAL_OSC_ENABLE;
  always_comb
  begin
    case (I_COUNTER_CLOCK_SELECT)
      CS_INSTR:
      begin
        src_tick = instr_tick;
      end
      CS_SYS:
      begin
        src_tick = 1'b1;
      end
      CS_EXT:
      begin
        if (xtal_src)
        begin
          src_tick = pin_rise[SB_XTAL];
        end
        else
        begin
          src_tick = pin_rise[SB_EXT] & arm_r;
        end
      end
      CS_RSVD:
      begin
        src_tick = 1'b0;
      end
      default:
      begin
        src_tick = 1'b0;
      end
    endcase
  end

  // Counter prescaler
  assign pre_last = (3'h1 << I_COUNTER_PRESCALE) - 3'h1;
  assign pre_tick = src_tick & (pre_r == pre_last);
  assign pre_nxt = (!I_COUNTER_ON || count_write) ? PRE_RST :
                   src_tick ? ((pre_r == pre_last) ? PRE_RST : pre_r + 3'h1) : pre_r;

  // Gate selection
  always_comb
  begin
    case (I_GATE_SOURCE)
      GATE_PIN:
      begin
        gate_level = pin_level[SB_GATE];
      end
      GATE_COMP_ONE:
      begin
        gate_level = pin_level[SB_COMP_ONE];
      end
      GATE_COMP_TWO:
      begin
        gate_level = pin_level[SB_COMP_TWO];
      end
      default:
      begin
        gate_level = 1'b0;
      end
    endcase
  end
  assign gate_ok = (gate_level == I_GATE_POLARITY);
  assign run = I_COUNTER_ON & (~I_COUNTER_GATE_ENABLE | gate_ok);
  assign count_step = run & pre_tick;

  // External edges: one extra resync stage when synchronised mode is chosen
  assign resync_nxt = count_step & ext_src & I_EXT_SYNC & ~count_write;
  assign inc_now = (ext_src && I_EXT_SYNC) ? resync_r : count_step;

  // Falling edge must arm the pin counter after write, off, or power-on
  assign arm_nxt = (!I_COUNTER_ON || count_write || !pin_src) ? 1'b0 :
                   pin_fall[SB_EXT] ? 1'b1 : arm_r;

  always_comb
  begin
    count_nxt = count_r;
    if (count_write)
    begin
      if (I_COUNT_HIGH_WR)
      begin
        count_nxt[15:8] = I_WR_DATA;
      end
      if (I_COUNT_LOW_WR)
      begin
        count_nxt[7:0] = I_WR_DATA;
      end
    end
    else if (inc_now && (I_COUNTER_ON || resync_r))
    begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // Capture pin: synced input, or the port latch when driven as output
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      cap_meta_r <= 1'b0;
      cap_sync_r <= 1'b0;
    end
    else
    begin
      cap_meta_r <= I_CAPTURE_PIN;
      cap_sync_r <= cap_meta_r;
    end
  end
  assign cap_level = I_PIN_DIRECTION ? cap_sync_r : I_PORT_LATCH;

  capture_unit u_capture (
    .i_clk(I_SYS_CLK),
    .i_arst_n(I_ARST_N),
    .i_instr_tick(instr_tick),
    .i_pin_level(cap_level),
    .i_mode(I_CAPTURE_MODE_FIELD),
    .i_count(count_r),
    .o_hold(hold),
    .o_capture(cap_fire)
  );

  // Sticky flag: a capture in the clearing cycle still sets it
  assign flag_nxt = cap_fire ? 1'b1 : (I_CAPTURE_IRQ_FLAG_CLR ? 1'b0 : flag_r);

  // Instruction phase runs free from reset
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      instr_q_r <= INSTR_RST;
    end
    else
    begin
      instr_q_r <= instr_q_nxt;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      count_r <= COUNT_RST;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  // Prescaler, falling-edge arm and resync stage
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      pre_r <= PRE_RST;
      arm_r <= 1'b0;
      resync_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_nxt;
      arm_r <= arm_nxt;
      resync_r <= resync_nxt;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      flag_r <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  // Pin drive follows the port bit and direction
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end
    else
    begin
      pin_out_r <= I_PORT_LATCH;
      pin_oe_r <= ~I_PIN_DIRECTION;
    end
  end

  assign O_COUNT_HIGH_BYTE = count_r[15:8];
  assign O_COUNT_LOW_BYTE = count_r[7:0];
  assign O_CAPTURE_HOLD_HIGH = hold[15:8];
  assign O_CAPTURE_HOLD_LOW = hold[7:0];
  assign O_CAPTURE_IRQ_FLAG = flag_r;
  assign O_CAPTURE_PIN_OUT = pin_out_r;
  assign O_CAPTURE_PIN_OE = pin_oe_r;
endmodule // timer16_with_edge_capture
`default_nettype wire

// [src/timer16_pkg.sv]
// Functional notes
// - Sixteen-bit up-counter; writing either byte replaces that byte at once.
// - Off bit stops counting; with gate enable set, counting follows the gate.
// - Clock select: 00 instruction, 01 system, 10 crystal or pin, 11 reserved.
// - Internal sources step through the counter prescaler; instruction source steps per cycle.
// - System clock source advances four counts per instruction cycle.
// - Gate may come from the gate pin or either comparator output.
// - External pin rising edges count, resynchronised or passed straight through.
// - Crystal oscillator input can serve as the counter time base.
// - External pin counting needs a falling edge before the first counted rising edge; the crystal source does not.
// - Qualifying capture pin event copies the whole count into the hold pair.
// - Capture modes: every falling, every rising, every 4th, every 16th rising.
// - Each capture sets the capture flag; only software clears it.
// - New capture overwrites held value; no overrun detection exists.
// - Capture pin driven as output: latch level changes can trigger captures.
// - Mode changes may raise a false capture; software clears the flag after.
// - Capture prescaler clears when capture is off, not capturing, or reset.
// - Switching between prescaler modes keeps the prescaler count.
package timer16_pkg;
  localparam int unsigned COUNT_W = 16;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [1:0] INSTR_RST = 2'h0;
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS = 2'h1;
  localparam logic [1:0] CS_EXT = 2'h2;
  localparam logic [1:0] CS_RSVD = 2'h3;
  localparam logic [1:0] GATE_PIN = 2'h0;
  localparam logic [1:0] GATE_COMP_ONE = 2'h1;
  localparam logic [1:0] GATE_COMP_TWO = 2'h2;
  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic [3:0] CAP_OFF = 4'h0;
  localparam logic [3:0] CAP_FALL = 4'h4;
  localparam logic [3:0] CAP_RISE = 4'h5;
  localparam logic [3:0] CAP_RISE4 = 4'h6;
  localparam logic [3:0] CAP_RISE16 = 4'h7;
  localparam logic [3:0] CAP_PS_RST = 4'h0;
  localparam logic [3:0] CAP_PS_LAST4 = 4'h3;
  localparam logic [3:0] CAP_PS_LAST16 = 4'hf;
  localparam int unsigned SYNC_BITS = 5;
  localparam int unsigned SB_GATE = 0;
  localparam int unsigned SB_COMP_ONE = 1;
  localparam int unsigned SB_COMP_TWO = 2;
  localparam int unsigned SB_EXT = 3;
  localparam int unsigned SB_XTAL = 4;

  function automatic logic is_capture_mode(input logic [3:0] mode);
    is_capture_mode = (mode == CAP_FALL) || (mode == CAP_RISE) || (mode == CAP_RISE4) || (mode == CAP_RISE16);
  endfunction
endpackage

// [src/pin_sync_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge
  import timer16_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic i_clk, // System clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] i_async, // Raw pin levels
  output logic [WIDTH-1:0] o_level, // Synchronised levels
  output logic [WIDTH-1:0] o_rise, // Rising edge pulse
  output logic [WIDTH-1:0] o_fall // Falling edge pulse
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] prev_r;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("pin_sync_edge needs WIDTH of at least one");
    end
    for (genvar b = 0; b < WIDTH; b++)
    begin : g_bit
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          meta_r[b] <= 1'b0;
          level_r[b] <= 1'b0;
          prev_r[b] <= 1'b0;
        end
        else
        begin
          meta_r[b] <= i_async[b];
          level_r[b] <= meta_r[b];
          prev_r[b] <= level_r[b];
        end
      end
      assign o_rise[b] = level_r[b] & ~prev_r[b];
      assign o_fall[b] = ~level_r[b] & prev_r[b];
    end
  endgenerate

  assign o_level = level_r;
endmodule // pin_sync_edge
`default_nettype wire

// [src/capture_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module capture_unit
  import timer16_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic i_instr_tick, // Instruction cycle strobe
  input wire logic i_pin_level, // Capture source level, same domain
  input wire logic [3:0] i_mode, // Capture mode field
  input wire logic [15:0] i_count, // Live count
  output logic [15:0] o_hold, // Held capture value
  output logic o_capture // One-cycle capture pulse
);
  logic samp_r;
  logic samp_nxt;
  logic [3:0] ps_r;
  logic [3:0] ps_nxt;
  logic [15:0] hold_r;
  logic cap_r;
  logic capturing;
  logic rise;
  logic fall;
  logic div_mode;
  logic [3:0] ps_last;
  logic ps_wrap;
  logic fire;

  assign capturing = is_capture_mode(i_mode);
  // Edges judged only on instruction ticks
  assign samp_nxt = i_instr_tick ? i_pin_level : samp_r;
  assign rise = i_instr_tick & i_pin_level & ~samp_r;
  assign fall = i_instr_tick & ~i_pin_level & samp_r;
  assign div_mode = (i_mode == CAP_RISE4) || (i_mode == CAP_RISE16);
  assign ps_last = (i_mode == CAP_RISE16) ? CAP_PS_LAST16 : CAP_PS_LAST4;
  assign ps_wrap = (ps_r >= ps_last);
  // Count kept across mode switches; cleared when capture stops or when the count wraps
  assign ps_nxt = !is_capture_mode(i_mode) ? CAP_PS_RST :
                  (div_mode && rise) ? (ps_wrap ? CAP_PS_RST : ps_r + 4'h1) : ps_r;
  assign fire = capturing &
                (((i_mode == CAP_FALL) && fall) ||
                 ((i_mode == CAP_RISE) && rise) ||
                 (div_mode && rise && ps_wrap));

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      samp_r <= 1'b0;
      ps_r <= CAP_PS_RST;
      hold_r <= COUNT_RST;
      cap_r <= 1'b0;
    end
    else
    begin
      samp_r <= samp_nxt;
      ps_r <= ps_nxt;
      cap_r <= fire;
      if (fire)
      begin
        hold_r <= i_count;
      end
    end
  end

  assign o_hold = hold_r;
  assign o_capture = cap_r;
endmodule // capture_unit
`default_nettype wire

// [sim/timer16_props.sv]
`timescale 1ns/1ps
`default_nettype none
module timer16_props
  import timer16_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = COUNT_W
)
(
  input wire logic I_SYS_CLK, // Clock
  input wire logic I_ARST_N, // Reset
  input wire logic I_COUNTER_ON, // Run
  input wire logic I_COUNTER_GATE_ENABLE, // Gate on
  input wire logic [1:0] I_COUNTER_CLOCK_SELECT, // Source
  input wire logic [1:0] I_COUNTER_PRESCALE, // Divide
  input wire logic [7:0] I_WR_DATA, // Data
  input wire logic I_COUNT_HIGH_WR, // High write
  input wire logic I_COUNT_LOW_WR, // Low write
  input wire logic [3:0] I_CAPTURE_MODE_FIELD, // Mode
  input wire logic I_CAPTURE_IRQ_FLAG_CLR, // Flag clear
  input wire logic [7:0] O_COUNT_HIGH_BYTE, // Count high
  input wire logic [7:0] O_COUNT_LOW_BYTE, // Count low
  input wire logic [7:0] O_CAPTURE_HOLD_HIGH, // Hold high
  input wire logic [7:0] O_CAPTURE_HOLD_LOW, // Hold low
  input wire logic O_CAPTURE_IRQ_FLAG // Flag
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  wire logic [15:0] cnt = {O_COUNT_HIGH_BYTE, O_COUNT_LOW_BYTE};
  wire logic [15:0] hold = {O_CAPTURE_HOLD_HIGH, O_CAPTURE_HOLD_LOW};
  wire logic nowr = !I_COUNT_HIGH_WR && !I_COUNT_LOW_WR;
  wire logic [1:0] sel = I_COUNTER_CLOCK_SELECT;
  AST_SYS_STEP: assert property (
    $past(I_COUNTER_ON) && !$past(I_COUNTER_GATE_ENABLE) && $past(nowr) && $past(sel) == CS_SYS
    && $past(I_COUNTER_PRESCALE) == 2'h0 |-> cnt == $past(cnt) + 16'h0001)
    else $error("count did not step on system clock");
  // Two cycles back so a resynchronised external tick is excluded
  AST_OFF_HOLD: assert property (
    !$past(I_COUNTER_ON) && $past(nowr) && $past(sel) != CS_EXT && $past(sel, 2) != CS_EXT
    |-> cnt == $past(cnt))
    else $error("count moved while off");
  AST_RSVD_HOLD: assert property (
    $past(sel) == CS_RSVD && $past(sel, 2) == CS_RSVD && $past(nowr) |-> $stable(cnt))
    else $error("count moved on reserved source");
  AST_WR_LOW: assert property (
    $past(I_COUNT_LOW_WR) |-> O_COUNT_LOW_BYTE == $past(I_WR_DATA))
    else $error("low byte write not taken");
  AST_WR_HIGH: assert property (
    $past(I_COUNT_HIGH_WR) |-> O_COUNT_HIGH_BYTE == $past(I_WR_DATA))
    else $error("high byte write not taken");
  AST_FLAG_STICKY: assert property (
    O_CAPTURE_IRQ_FLAG && !I_CAPTURE_IRQ_FLAG_CLR |=> O_CAPTURE_IRQ_FLAG)
    else $error("flag dropped without clear");
  AST_FLAG_CLR: assert property (
    I_CAPTURE_IRQ_FLAG_CLR && I_CAPTURE_MODE_FIELD == CAP_OFF && $past(I_CAPTURE_MODE_FIELD) == CAP_OFF
    |=> !O_CAPTURE_IRQ_FLAG)
    else $error("flag clear ignored");
  AST_HOLD_OFF: assert property (
    $past(I_CAPTURE_MODE_FIELD) == CAP_OFF |-> $stable(hold))
    else $error("hold changed with capture off");
endmodule // timer16_props
bind timer16_with_edge_capture timer16_props #(.COUNT_WIDTH(COUNT_WIDTH)) u_props (.*);
`default_nettype wire

// [sim/cap_source.sv]
`timescale 1ns/1ps
`default_nettype none
module cap_source
(
  input wire logic i_clk, // Pacing clock
  output logic [2:0] o_pins // Ext clock, crystal, capture
);
  initial o_pins = 3'h0;
  // Whole pulses, moved on falling edges
  task automatic pulse(input int which, input int n, input int w);
    repeat (n)
    begin
      o_pins[which] = 1'b1;
      repeat (w) @(negedge i_clk);
      o_pins[which] = 1'b0;
      repeat (w) @(negedge i_clk);
    end
  endtask
endmodule // cap_source
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import timer16_pkg::*;
  logic I_SYS_CLK = '0;
  logic I_ARST_N = '0;
  logic I_COUNTER_ON = '0;
  logic I_COUNTER_GATE_ENABLE = '0;
  logic I_CRYSTAL_OSC_ENABLE = '0;
  logic I_EXT_SYNC = '0;
  logic I_GATE_POLARITY = '1;
  logic I_COUNT_GATE_PIN = '0;
  logic I_COMPARATOR_ONE = '0;
  logic I_COMPARATOR_TWO = '0;
  logic I_COUNT_HIGH_WR = '0;
  logic I_COUNT_LOW_WR = '0;
  logic I_PIN_DIRECTION = '1;
  logic I_PORT_LATCH = '0;
  logic I_CAPTURE_IRQ_FLAG_CLR = '0;
  logic [1:0] I_COUNTER_CLOCK_SELECT = '0;
  logic [1:0] I_COUNTER_PRESCALE = '0;
  logic [1:0] I_GATE_SOURCE = '0;
  logic [7:0] I_WR_DATA = '0;
  logic [3:0] I_CAPTURE_MODE_FIELD = '0;
  wire logic [2:0] pins;
  wire logic I_EXT_COUNT_CLOCK_PIN = pins[0];
  wire logic I_CRYSTAL_CLK = pins[1];
  wire logic I_CAPTURE_PIN = pins[2];
  wire logic [7:0] O_COUNT_HIGH_BYTE, O_COUNT_LOW_BYTE, O_CAPTURE_HOLD_HIGH, O_CAPTURE_HOLD_LOW;
  wire logic O_CAPTURE_IRQ_FLAG, O_CAPTURE_PIN_OUT, O_CAPTURE_PIN_OE;
  wire logic [15:0] cnt = {O_COUNT_HIGH_BYTE, O_COUNT_LOW_BYTE};
  wire logic [15:0] hold = {O_CAPTURE_HOLD_HIGH, O_CAPTURE_HOLD_LOW};
  wire logic [15:0] flg = {15'h0000, O_CAPTURE_IRQ_FLAG};
  logic [3:0] mds [4] = '{CAP_FALL, CAP_RISE, CAP_RISE4, CAP_RISE16};
  int nns [4] = '{1, 1, 4, 16};
  int num_errors = 0;
  int checks = 0;
  timer16_with_edge_capture uut (.*);
  cap_source u_src (.i_clk(I_SYS_CLK), .o_pins(pins));
  initial
    forever #50 I_SYS_CLK = ~I_SYS_CLK;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge I_SYS_CLK);
  endtask
  task automatic wr(input logic [15:0] v);
    I_WR_DATA = v[7:0];
    I_COUNT_LOW_WR = '1;
    cyc(1);
    I_WR_DATA = v[15:8];
    I_COUNT_LOW_WR = '0;
    I_COUNT_HIGH_WR = '1;
    cyc(1);
    I_COUNT_HIGH_WR = '0;
  endtask
  task automatic span(input logic [1:0] sel, input int n, input logic [15:0] exp);
    wr(16'h0000);
    I_COUNTER_CLOCK_SELECT = sel;
    I_COUNTER_ON = '1;
    cyc(n);
    I_COUNTER_ON = '0;
    cyc(2);
    chk(cnt, exp);
  endtask
  task automatic clr();
    I_CAPTURE_IRQ_FLAG_CLR = '1;
    cyc(1);
    I_CAPTURE_IRQ_FLAG_CLR = '0;
    cyc(1);
  endtask
  task automatic capt(input logic [3:0] md, input int n, input int w, input logic [15:0] v);
    I_CAPTURE_MODE_FIELD = CAP_OFF;
    cyc(2);
    I_CAPTURE_MODE_FIELD = md;
    cyc(8);
    clr();
    wr(v);
    u_src.pulse(2, n - 1, w);
    cyc(8);
    chk(flg, 16'h0000);
    u_src.pulse(2, 1, w);
    cyc(8);
    chk(flg, 16'h0001);
    chk(hold, v);
    wr(~v);
    u_src.pulse(2, n, w);
    cyc(8);
    chk(hold, ~v);
    chk(flg, 16'h0001);
    clr();
    chk(flg, 16'h0000);
  endtask
  initial
  begin
    cyc(16);
    I_ARST_N = '1;
    cyc(2);
    wr(16'h55AA);
    cyc(10);
    chk(cnt, 16'h55AA);
    span(CS_SYS, 10, 16'h000A);
    span(CS_INSTR, 40, 16'h000A);
    for (int p = 1; p < 4; p++)
    begin
      I_COUNTER_PRESCALE = 2'(p);
      span(CS_SYS, 10 << p, 16'h000A);
    end
    I_COUNTER_PRESCALE = 2'h0;
    span(CS_RSVD, 20, 16'h0000);
    I_COUNTER_GATE_ENABLE = '1;
    for (int s = 0; s < 3; s++)
    begin
      I_GATE_SOURCE = 2'(s);
      {I_COMPARATOR_TWO, I_COMPARATOR_ONE, I_COUNT_GATE_PIN} = 3'h1 << s;
      cyc(4);
      span(CS_SYS, 10, 16'h000A);
      {I_COMPARATOR_TWO, I_COMPARATOR_ONE, I_COUNT_GATE_PIN} = 3'h0;
      cyc(4);
      span(CS_SYS, 10, 16'h0000);
    end
    // Low gate permits counting when polarity is low
    I_GATE_POLARITY = '0;
    span(CS_SYS, 10, 16'h000A);
    I_GATE_POLARITY = '1;
    I_COUNTER_GATE_ENABLE = '0;
    I_COUNTER_CLOCK_SELECT = CS_EXT;
    for (int s = 0; s < 2; s++)
    begin
      I_EXT_SYNC = s[0];
      wr(16'h0000);
      I_COUNTER_ON = '1;
      // First rise is ignored until a fall has been seen
      u_src.pulse(0, 5, 3);
      cyc(4);
      chk(cnt, 16'h0004);
      I_COUNTER_ON = '0;
    end
    I_CRYSTAL_OSC_ENABLE = '1;
    wr(16'h0000);
    I_COUNTER_ON = '1;
    u_src.pulse(1, 4, 3);
    cyc(4);
    chk(cnt, 16'h0004);
    I_COUNTER_ON = '0;
    I_CRYSTAL_OSC_ENABLE = '0;
    I_COUNTER_CLOCK_SELECT = CS_INSTR;
    for (int i = 0; i < 4; i++)
      capt(mds[i], nns[i], (i == 0) ? 20 : 6, 16'hA5C0 + 16'(i));
    I_CAPTURE_MODE_FIELD = CAP_RISE4;
    cyc(8);
    clr();
    u_src.pulse(2, 2, 6);
    I_CAPTURE_MODE_FIELD = CAP_OFF;
    cyc(2);
    I_CAPTURE_MODE_FIELD = CAP_RISE4;
    cyc(8);
    clr();
    u_src.pulse(2, 2, 6);
    cyc(8);
    chk(flg, 16'h0000);
    u_src.pulse(2, 2, 6);
    cyc(8);
    chk(flg, 16'h0001);
    // Two rises in 4th mode, then a direct switch keeps the count
    clr();
    u_src.pulse(2, 2, 6);
    I_CAPTURE_MODE_FIELD = CAP_RISE16;
    cyc(8);
    clr();
    u_src.pulse(2, 13, 6);
    cyc(8);
    chk(flg, 16'h0000);
    u_src.pulse(2, 1, 6);
    cyc(8);
    chk(flg, 16'h0001);
    I_CAPTURE_MODE_FIELD = CAP_OFF;
    cyc(2);
    I_CAPTURE_MODE_FIELD = CAP_RISE;
    I_PIN_DIRECTION = '0;
    cyc(8);
    clr();
    wr(16'h7777);
    I_PORT_LATCH = '1;
    cyc(8);
    chk(flg, 16'h0001);
    chk(hold, 16'h7777);
    chk({14'h0000, O_CAPTURE_PIN_OE, O_CAPTURE_PIN_OUT}, 16'h0003);
    I_CAPTURE_MODE_FIELD = CAP_OFF;
    cyc(2);
    clr();
    chk(flg, 16'h0000);
    end_sim();
  end
  initial
  begin
    #1000000;
    num_errors++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
